/* hw/pwp_map.svh */
`ifndef PWP_MAP_SVH
`define PWP_MAP_SVH

// ----------------------------------------------------------------
// register offsets, byte addresses on the apb bus
// ----------------------------------------------------------------
`define PWP_OFS_CLR 12'h000
`define PWP_OFS_SET 12'h004

// ----------------------------------------------------------------
// reset values per bridge instance
// ----------------------------------------------------------------
`define PWP_RST_A 32'h0000_0000
`define PWP_RST_B 32'h0000_0002
`define PWP_RST_C 32'h0080_0000

// ----------------------------------------------------------------
// implemented protect bits per bridge instance
// ----------------------------------------------------------------
// a: bits 6..1, b: bits 6,3,2,1, c: bits 18..16
`define PWP_MASK_A 32'h0000_007e
`define PWP_MASK_B 32'h0000_004e
`define PWP_MASK_C 32'h0007_0000

// byte lane width and lane count of the data word
`define PWP_LANE_W 8
`define PWP_LANES  4

`endif

/* hw/pwp_pkg.sv */
`include "pwp_map.svh"

package pwp_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWP_BRIDGE_A,
    PWP_BRIDGE_B,
    PWP_BRIDGE_C
  } pwp_bridge_e;

  typedef enum logic [1:0] {
    PWP_REG_NONE,
    PWP_REG_CLR,
    PWP_REG_SET
  } pwp_reg_e;

  typedef struct packed {
    logic [31:0] prot;
    logic [31:0] rdata;
    logic        first;
  } pwp_top_s;

  typedef struct packed {
    logic [31:0] blocked;
  } pwp_gate_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte strobes widened to a bit mask
  function automatic logic [31:0] pwp_strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < `PWP_LANES; i++) begin
      m[i*`PWP_LANE_W +: `PWP_LANE_W] = {`PWP_LANE_W{s[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] pwp_rst_val(input pwp_bridge_e b);
    case (b)
      PWP_BRIDGE_B: return `PWP_RST_B;
      PWP_BRIDGE_C: return `PWP_RST_C;
      default:      return `PWP_RST_A;
    endcase
  endfunction

  function automatic logic [31:0] pwp_impl_mask(input pwp_bridge_e b);
    case (b)
      PWP_BRIDGE_B: return `PWP_MASK_B;
      PWP_BRIDGE_C: return `PWP_MASK_C;
      default:      return `PWP_MASK_A;
    endcase
  endfunction

endpackage

/* hw/pwp_lane_update.sv */
`include "pwp_map.svh"

// per-lane set / clear merge of the protect state
module pwp_lane_update (
  input  wire logic [31:0] cur_state,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  strb,
  input  wire logic        set_en,
  input  wire logic        clr_en,
  input  wire logic [31:0] impl_mask,
  output logic      [31:0] next_state
);

  // ----------------------------------------------------------------
  // lane merge
  // ----------------------------------------------------------------
  logic [31:0] hit;

  // only ones inside enabled lanes and implemented bits act
  assign hit = wdata & pwp_pkg::pwp_strb_mask(strb) & impl_mask; // [R1]

  genvar g;
  generate
    for (g = 0; g < `PWP_LANES; g++) begin : g_lane
      localparam int LO = g * `PWP_LANE_W;
      // zeros leave the bit alone in both registers
      always_comb begin
        next_state[LO +: `PWP_LANE_W] = cur_state[LO +: `PWP_LANE_W];
        if (set_en) begin
          next_state[LO +: `PWP_LANE_W] =
            cur_state[LO +: `PWP_LANE_W] | hit[LO +: `PWP_LANE_W]; // [R9]
        end else if (clr_en) begin
          next_state[LO +: `PWP_LANE_W] =
            cur_state[LO +: `PWP_LANE_W] & ~hit[LO +: `PWP_LANE_W]; // [R3]
        end
      end
    end
  endgenerate

endmodule

/* hw/pwp_wr_gate.sv */
// write gate between the bridge and its peripherals
module pwp_wr_gate (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] prot,
  input  wire logic [31:0] wr_req,
  output logic      [31:0] wr_en,
  output logic      [31:0] wr_blocked
);

  // ----------------------------------------------------------------
  // gating
  // ----------------------------------------------------------------
  pwp_pkg::pwp_gate_s q;
  pwp_pkg::pwp_gate_s d;

  // combinational so the peripheral sees the gate in the same cycle
  assign wr_en = wr_req & ~prot; // [R10]

  // one-cycle pulse per refused write
  always_comb begin
    d         = q;
    d.blocked = wr_req & prot; // [R10]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wr_blocked = q.blocked;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  gate_block_a : assert property ( // [R10]
    (wr_en & prot) == '0
  ) else $error("write passed to a protected peripheral");

  gate_flag_a : assert property ( // [R10]
    (wr_req & prot) != '0 |=> wr_blocked == $past(wr_req & prot)
  ) else $error("blocked write not flagged");

endmodule

/* hw/pwp_top.sv */
// The implementer's own choice: the APB interface to the registers.
`include "pwp_map.svh"

// Function
// [R1] byte, halfword and word writes act only on their enabled lanes
// [R2] a zero written to the clear register changes nothing
// [R3] a one written to the clear register unprotects that bit only
// [R4] a protect bit reads one when protected, zero when not
// [R5] first bridge clear register at 0x00, resets zero, six bits
// [R6] first bridge set register at 0x04 resets to zero
// [R7] second bridge set register resets with debug service bit set
// [R8] third bridge clear register resets to 0x00800000, bits 16-18
// [R9] a one to the set register protects; both registers read same
// [R10] writes to a protected peripheral are blocked and lost

module pwp_top #(
  parameter pwp_pkg::pwp_bridge_e BRIDGE = pwp_pkg::PWP_BRIDGE_A
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] periph_wr_req,
  output logic      [31:0] periph_wr_en,
  output logic      [31:0] periph_wr_blocked,
  output logic      [31:0] protect_state
);

  // ----------------------------------------------------------------
  // instance constants
  // ----------------------------------------------------------------
  // resolved at elaboration so each bridge flavour costs no decode logic
  localparam logic [31:0] RST  = pwp_pkg::pwp_rst_val(BRIDGE);
  localparam logic [31:0] MASK = pwp_pkg::pwp_impl_mask(BRIDGE);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // used for the read capture and the write commit
  // exact compares: the upper address bits are decoded, so aliases of
  // the two registers answer as holes rather than as copies
  function automatic pwp_pkg::pwp_reg_e reg_sel(input logic [11:0] a);
    if (a == `PWP_OFS_CLR) begin
      return pwp_pkg::PWP_REG_CLR;
    end else if (a == `PWP_OFS_SET) begin
      return pwp_pkg::PWP_REG_SET;
    end else begin
      return pwp_pkg::PWP_REG_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  pwp_pkg::pwp_top_s q;
  pwp_pkg::pwp_top_s d;
  pwp_pkg::pwp_reg_e sel;
  logic              setup;
  logic              access;
  logic              hit;
  logic              wr_set;
  logic              wr_clr;
  logic [31:0]       prot_upd;

  // phase and target of the current transfer
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign sel    = reg_sel(paddr);
  assign hit    = (sel != pwp_pkg::PWP_REG_NONE);

  // a write only commits at the access edge
  assign wr_set = access & pwrite & (sel == pwp_pkg::PWP_REG_SET);
  assign wr_clr = access & pwrite & (sel == pwp_pkg::PWP_REG_CLR);

  // ----------------------------------------------------------------
  // protect state update
  // ----------------------------------------------------------------
  pwp_lane_update u_lane (
    .cur_state  (q.prot),
    .wdata      (pwdata),
    .strb       (pstrb),
    .set_en     (wr_set),
    .clr_en     (wr_clr),
    .impl_mask  (MASK),
    .next_state (prot_upd)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // read data is captured in the setup cycle so prdata comes from a
  // flop and the slave can still answer with no wait state
  always_comb begin
    d       = q;
    d.prot  = prot_upd; // [R2] [R3] [R9]
    d.first = 1'b1;
    if (setup && !pwrite) begin
      if (hit) begin
        d.rdata = q.prot; // [R4] [R9]
      end else begin
        d.rdata = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // unimplemented bits keep their reset value forever, which is why
  // bit 23 of the third bridge stays high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.prot  <= RST; // [R5] [R6] [R7] [R8]
      q.rdata <= '0;
      q.first <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait state; unmapped offsets answer with an error
  // pslverr comes from the live bus phase so it never lags the answer;
  // the cost is a combinational path from paddr to the error flag
  assign pready        = 1'b1;
  assign pslverr       = access & ~hit;
  assign prdata        = q.rdata;
  assign protect_state = q.prot;

  // ----------------------------------------------------------------
  // peripheral write gate
  // ----------------------------------------------------------------
  pwp_wr_gate u_gate (
    .pclk       (pclk),
    .presetn    (presetn),
    .prot       (q.prot),
    .wr_req     (periph_wr_req),
    .wr_en      (periph_wr_en),
    .wr_blocked (periph_wr_blocked)
  ); // [R10]

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bits that the current write may touch
  logic [31:0] wbits;
  logic [31:0] lane_m;

  assign lane_m = pwp_pkg::pwp_strb_mask(pstrb);
  assign wbits  = pwdata & lane_m & MASK;

  // values seen in the first cycle after reset release
  rst_value_a : assert property ( // [R5] [R6] [R7] [R8]
    !q.first |-> protect_state == RST
  ) else $error("protect state not at reset value");

  // bits outside the implemented set never move
  fixed_bits_a : assert property ( // [R5] [R7] [R8]
    (protect_state & ~MASK) == (RST & ~MASK)
  ) else $error("unimplemented protect bit changed");

  // zeros in a clear write leave every other bit alone
  clr_zero_keep_a : assert property ( // [R2]
    wr_clr |=> ((protect_state ^ $past(protect_state))
                & ~$past(wbits)) == '0
  ) else $error("clear write disturbed an unselected bit");

  // ones in a clear write unprotect exactly those bits
  clr_one_a : assert property ( // [R3]
    wr_clr |=> (protect_state & $past(wbits)) == '0
  ) else $error("clear write did not unprotect");

  // ones in a set write protect exactly those bits
  set_one_a : assert property ( // [R9]
    wr_set |=> ((protect_state & $past(wbits)) == $past(wbits))
           && ((protect_state ^ $past(protect_state))
               & ~$past(wbits)) == '0
  ) else $error("set write wrong");

  // disabled byte lanes are never written
  lane_keep_a : assert property ( // [R1]
    (wr_set || wr_clr) |=>
      ((protect_state ^ $past(protect_state))
       & ~$past(lane_m)) == '0
  ) else $error("write reached a disabled byte lane");

  // a read of either register returns the live state
  read_state_a : assert property ( // [R4] [R9]
    setup && !pwrite && hit
      ##1 access && !pwrite |-> prdata == protect_state
  ) else $error("read data differs from protect state");

  // state only moves on a mapped write access
  no_spurious_a : assert property ( // [R2] [R9]
    !(wr_set || wr_clr) |=> $stable(protect_state)
  ) else $error("protect state changed without a write");

  // protected peripherals never see a write strobe
  gate_block_a : assert property ( // [R10]
    (periph_wr_en & protect_state) == '0
  ) else $error("write passed to protected peripheral");

  // unprotected peripheral writes pass unchanged
  gate_pass_a : assert property ( // [R10]
    (periph_wr_en & ~protect_state) == (periph_wr_req & ~protect_state)
  ) else $error("write to unprotected peripheral dropped");

  // unmapped access answers with an error in the same cycle
  unmapped_err_a : assert property (
    access && !hit |-> pslverr && pready
  ) else $error("unmapped access without error");

  // ----------------------------------------------------------------
  // bus answer checks
  // ----------------------------------------------------------------
  // zero wait state: every access phase is answered at once
  ready_now_a : assert property (
    access |-> pready
  ) else $error("access phase not answered");

  // mapped offsets never answer with an error
  mapped_ok_a : assert property ( // [R5] [R6]
    access && hit |-> !pslverr
  ) else $error("mapped access answered with an error");

  // the error flag only rides on an access phase
  err_access_a : assert property (
    !access |-> !pslverr
  ) else $error("error flag outside an access phase");

  // read data stands until the next read setup
  rdata_hold_a : assert property ( // [R4]
    !(setup && !pwrite) |=> $stable(prdata)
  ) else $error("read data moved without a read");

  // a read of a hole returns zero, never a stale word
  hole_zero_a : assert property (
    setup && !pwrite && !hit |=> prdata == '0
  ) else $error("unmapped read returned data");

  // either offset captures the live state of the setup cycle
  same_view_a : assert property ( // [R9]
    setup && !pwrite && hit |=> prdata == $past(protect_state)
  ) else $error("read capture differs from protect state");

  // no read has been captured yet right after reset
  rst_rdata_a : assert property (
    !q.first |-> prdata == '0
  ) else $error("read data not cleared by reset");

  // ----------------------------------------------------------------
  // state update checks
  // ----------------------------------------------------------------
  // a clear write never protects anything
  clr_no_set_a : assert property ( // [R3]
    wr_clr |=> (protect_state & ~$past(protect_state)) == '0
  ) else $error("clear write protected a bit");

  // a write to a hole leaves the protect state alone
  hole_keep_a : assert property ( // [R2] [R9]
    access && pwrite && !hit |=> $stable(protect_state)
  ) else $error("unmapped write changed the protect state");

  // a refused write is flagged for one cycle and then dropped
  blocked_once_a : assert property ( // [R10]
    (periph_wr_req & protect_state) == '0 |=> periph_wr_blocked == '0
  ) else $error("blocked flag without a refused write");

  // ----------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------
  set_then_clr_c : cover property (
    wr_set && pwdata != '0 ##[1:20] wr_clr && pwdata != '0
  );

  byte_write_c : cover property (
    (wr_set || wr_clr) && pstrb != 4'hf
  );

  blocked_c : cover property (
    (periph_wr_req & protect_state) != '0
  );

  read_back_c : cover property (
    access && !pwrite && hit && prdata != '0
  );

  zero_clear_c : cover property (
    wr_clr && pstrb == 4'hf && pwdata == '0
  );

endmodule

/* verif/pwp_top_tb.sv */
`include "pwp_map.svh"

module pwp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // constants, signals and the three bridge instances
  // ------------------------------------------------------------
  localparam logic [31:0] RST [3] = '{`PWP_RST_A, `PWP_RST_B, `PWP_RST_C};
  localparam logic [31:0] MSK [3] = '{`PWP_MASK_A, `PWP_MASK_B, `PWP_MASK_C};
  localparam logic [3:0]  STB [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc};
  localparam logic [11:0] CLR     = `PWP_OFS_CLR;
  localparam logic [11:0] SET     = `PWP_OFS_SET;

  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] req;
  logic [31:0] prdata  [3];
  logic        pready  [3];
  logic        pslverr [3];
  logic [31:0] wr_en   [3];
  logic [31:0] blocked [3];
  logic [31:0] state   [3];
  logic [31:0] rd      [3];
  logic        er      [3];
  logic [31:0] exp     [3];
  int          num_errors;
  int          n_tests;

  // one instance per bridge flavour, all on the same bus
  for (genvar g = 0; g < 3; g++) begin : g_br
    pwp_top #(
      .BRIDGE (pwp_pkg::pwp_bridge_e'(g))
    ) i_dut (
      .pclk              (pclk),
      .presetn           (presetn),
      .paddr             (paddr),
      .psel              (psel),
      .penable           (penable),
      .pwrite            (pwrite),
      .pwdata            (pwdata),
      .pstrb             (pstrb),
      .prdata            (prdata[g]),
      .pready            (pready[g]),
      .pslverr           (pslverr[g]),
      .periph_wr_req     (req),
      .periph_wr_en      (wr_en[g]),
      .periph_wr_blocked (blocked[g]),
      .protect_state     (state[g])
    );
  end

  // free running clock, 4 ns period
  always #2 pclk = ~pclk;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  // one apb transfer; leaves psel up so a next call runs back to back
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int          n;
    logic [31:0] m;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready[0] !== 1'b1 && n < 16);
    if (pready[0] !== 1'b1) begin
      num_errors++;
      test_done();
    end
    for (int k = 0; k < 3; k++) begin
      rd[k] = prdata[k];
      er[k] = pslverr[k];
      // expected state: only enabled lanes and implemented bits move
      for (int i = 0; i < 4; i++)
        m[i*8 +: 8] = {8{s[i]}};
      m = m & MSK[k] & d;
      if (wr && a == CLR)
        exp[k] = exp[k] & ~m;
      if (wr && a == SET)
        exp[k] = exp[k] | m;
    end
  endtask

  // release the bus, then look at the live protect bits mid-cycle
  task automatic idle_chk();
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
    for (int k = 0; k < 3; k++)
      chk(state[k], exp[k]);
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000, 4'hf);
    for (int k = 0; k < 3; k++) begin
      chk(rd[k], exp[k]);
      chk({31'h0, er[k]}, 32'h0);
    end
  endtask

  // every request line on at once, then off to see the blocked pulse
  task automatic gate();
    req <= 32'hffff_ffff;
    @(negedge pclk);
    for (int k = 0; k < 3; k++)
      chk(wr_en[k], ~exp[k]);
    @(posedge pclk);
    req <= 32'h0000_0000;
    @(negedge pclk);
    for (int k = 0; k < 3; k++) begin
      chk(blocked[k], exp[k]);
      chk(wr_en[k], 32'h0000_0000);
    end
    @(posedge pclk);
    // the refused-write flag is a pulse, so it must be gone again
    @(negedge pclk);
    for (int k = 0; k < 3; k++)
      chk(blocked[k], 32'h0000_0000);
    @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 3; k++)
      exp[k] = RST[k];
    @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    req = 32'h0000_0000;
    num_errors = 0;
    n_tests = 0;
    @(posedge pclk);
    do_reset();
    idle_chk();
    rdchk(CLR);
    rdchk(SET);
    idle_chk();
    gate();
    $display("test reset values done");
    // set all, read back at the other offset with no idle between
    apb(1'b1, SET, 32'hffff_ffff, 4'hf);
    rdchk(CLR);
    idle_chk();
    apb(1'b1, CLR, 32'h0000_0000, 4'hf);
    idle_chk();
    gate();
    $display("test set and zero clear done");
    // single ones clear only their own bits
    apb(1'b1, CLR, 32'h0001_0014, 4'hf);
    rdchk(SET);
    idle_chk();
    gate();
    $display("test single bit clear done");
    // byte and halfword lanes touch nothing outside themselves
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, SET, 32'hffff_ffff, 4'hf);
      apb(1'b1, CLR, 32'hffff_ffff, STB[i]);
      idle_chk();
      apb(1'b1, SET, 32'hffff_ffff, STB[i]);
      rdchk(CLR);
      idle_chk();
    end
    $display("test lane access done");
    // a hole in the map is refused and leaves the state alone
    apb(1'b1, 12'h008, 32'hffff_ffff, 4'hf);
    for (int k = 0; k < 3; k++)
      chk({31'h0, er[k]}, 32'h1);
    apb(1'b0, 12'h008, 32'h0000_0000, 4'hf);
    for (int k = 0; k < 3; k++)
      chk(rd[k], 32'h0000_0000);
    idle_chk();
    $display("test unmapped done");
    // a second reset mid-run restores every instance
    do_reset();
    idle_chk();
    rdchk(SET);
    idle_chk();
    $display("test second reset done");
    test_done();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    test_done();
  end

endmodule
